// ### rtl/aps_power_up_sequencer.sv
// Start-up sequencer of an eight-channel delta-sigma converter.
// Assumes all inputs are synchronous to ref_clk; resetn is the power-on reset.
//
// Summary of operation
// - Internal oscillator needs 20 us to start.
// - Reset rise releases filters, starts conversion.
// - First data-ready fall marks settled data.
// - Valid data follows 2.2 ms after release.
// - Valid data within 3 ms of power-up.
// - Register write restarts the settling interval.
// - Rate change applies new settling time.
`timescale 1ns/1ps
`default_nettype none
module aps_power_up_sequencer
#(
    parameter int unsigned OSC_START_CYC_P = aps_pkg::OSC_START_CYC,
    parameter int unsigned STABLE_CYC_P = aps_pkg::STABLE_CYC,
    parameter int unsigned DEADLINE_CYC_P = aps_pkg::DEADLINE_CYC,
    parameter int unsigned CONV_PERIOD_4K_P = aps_pkg::CONV_PERIOD_4K_CYC
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Supply and clock source
    input wire logic supplyGood,
    input wire logic useIntOsc,
    // Converter reset pin, active low
    input wire logic convResetN,
    // Serial-port command completion
    input wire logic regWriteDone,
    input wire logic rateChangeDone,
    input wire logic [aps_pkg::RATE_W-1:0] newRate,
    // Status
    output logic oscReady,
    output logic filterRun,
    output logic conversionDoneN,
    output logic firstSettled,
    output logic dataValid,
    output logic startupLate,
    output logic [aps_pkg::RATE_W-1:0] dataRate
);
    import aps_pkg::*;

    aps_timer_if convTmr ();
    aps_timer_if stableTmr ();

    aps_state_e state;
    aps_state_e next_state;
    logic [CNT_W-1:0] oscAge;
    logic [CNT_W-1:0] powerAge;
    logic stableDone;

    // Clamp unused rate codes to the fastest rate
    function automatic logic [RATE_W-1:0] clampRate(input logic [RATE_W-1:0] rate);
        clampRate = (rate > RATE_MAX) ? RATE_MAX : rate;
    endfunction

    // Conversion period for a rate code
    function automatic logic [CNT_W-1:0] periodCycles(input logic [RATE_W-1:0] rate);
        periodCycles = CNT_W'((CONV_PERIOD_4K_P << 2) >> clampRate(rate));
    endfunction

    // Event decode
    wire oscDone = (oscAge == CNT_W'(OSC_START_CYC_P - 1));
    wire startConv = (state == ST_HOLD) && convResetN;
    wire converting = (state == ST_SETTLE) || (state == ST_RUN);
    wire restartReq = converting && (regWriteDone || rateChangeDone);
    wire [RATE_W-1:0] effRate = rateChangeDone ? clampRate(newRate) : dataRate;
    wire drdyFire = converting && convResetN && supplyGood && convTmr.expired && !restartReq;
    wire deadlineHit = (powerAge == CNT_W'(DEADLINE_CYC_P - 1));

    // Settling then period timer; the strobe cycle itself is one period cycle
    assign convTmr.load = startConv || restartReq || drdyFire;
    assign convTmr.loadValue = drdyFire ? periodCycles(dataRate) - CNT_W'(1) :
        settleCycles(effRate);
    // Stable-time timer from reset release
    assign stableTmr.load = startConv;
    assign stableTmr.loadValue = CNT_W'(STABLE_CYC_P);

    aps_timer convTimer
    (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .bus(convTmr.tmr)
    );

    aps_timer stableTimer
    (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .bus(stableTmr.tmr)
    );

    // Sequencer transitions
    always_comb
    begin
        next_state = state;
        case (state)
            ST_OFF:
                if (supplyGood)
                    next_state = useIntOsc ? ST_OSC : ST_HOLD;
            ST_OSC:
                if (oscDone)
                    next_state = ST_HOLD;
            ST_HOLD:
                if (convResetN)
                    next_state = ST_SETTLE;
            ST_SETTLE:
                if (drdyFire)
                    next_state = ST_RUN;
            ST_RUN:
                if (restartReq)
                    next_state = ST_SETTLE;
            default:
                next_state = ST_OFF;
        endcase
        if (!supplyGood)
            next_state = ST_OFF;
        else if (converting && !convResetN)
            next_state = ST_HOLD;
    end

    // State and timing counters
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= ST_OFF;
            oscAge <= '0;
            powerAge <= '0;
        end
        else
        begin
            state <= next_state;
            oscAge <= (state == ST_OSC) ? oscAge + CNT_W'(1) : '0;
            if (!supplyGood)
                powerAge <= '0;
            else if (!deadlineHit)
                powerAge <= powerAge + CNT_W'(1);
        end
    end

    // Oscillator, filter and rate status
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            oscReady <= 1'b0;
            filterRun <= 1'b0;
            dataRate <= RATE_DEFAULT;
        end
        else
        begin
            if (!supplyGood || !useIntOsc)
                oscReady <= 1'b0;
            else if (state == ST_OSC && oscDone)
                oscReady <= 1'b1;
            filterRun <= (next_state == ST_SETTLE) || (next_state == ST_RUN);
            if (!supplyGood)
                dataRate <= RATE_DEFAULT;
            else if (rateChangeDone)
                dataRate <= clampRate(newRate);
        end
    end

    // Data-ready strobe and validity flags
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            conversionDoneN <= 1'b1;
            firstSettled <= 1'b0;
            stableDone <= 1'b0;
            dataValid <= 1'b0;
            startupLate <= 1'b0;
        end
        else
        begin
            conversionDoneN <= !drdyFire;
            if (!converting || startConv)
                stableDone <= 1'b0;
            else if (stableTmr.expired)
                stableDone <= 1'b1;
            if (startConv || !supplyGood)
                firstSettled <= 1'b0;
            else if (drdyFire)
                firstSettled <= 1'b1;
            if (!converting)
                dataValid <= 1'b0;
            else if (drdyFire && stableDone)
                dataValid <= 1'b1;
            if (!supplyGood)
                startupLate <= 1'b0;
            else if (deadlineHit && !dataValid && !(drdyFire && stableDone))
                startupLate <= 1'b1;
        end
    end

    // Helper: age of the current settling interval
    logic [CNT_W-1:0] settleAge;
    logic [CNT_W-1:0] settleTarget;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            settleAge <= '0;
            settleTarget <= '0;
        end
        else if (startConv || restartReq)
        begin
            settleAge <= '0;
            settleTarget <= settleCycles(effRate);
        end
        else
            settleAge <= settleAge + CNT_W'(1);
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence seqStart;
        state == ST_HOLD && convResetN && supplyGood;
    endsequence

    sequence seqSettleDone;
        state == ST_SETTLE && drdyFire;
    endsequence

    AST_FILTER_RELEASE: assert property (seqStart |=> filterRun && state == ST_SETTLE)
        else $error("filters not released on reset rise");
    AST_FIRST_EDGE: assert property (seqSettleDone |=> !conversionDoneN ##1 conversionDoneN)
        else $error("first data-ready pulse malformed");
    AST_SETTLE_LEN: assert property (seqSettleDone |-> settleAge == settleTarget)
        else $error("settling interval length wrong");
    AST_REG_WRITE: assert property (converting && regWriteDone && convResetN |=>
        state == ST_SETTLE && settleAge == '0) else $error("write did not restart settling");
    AST_RATE_APPLY: assert property (rateChangeDone && supplyGood |=>
        dataRate == clampRate($past(newRate))) else $error("rate change not applied");
    AST_VALID_GATE: assert property (dataValid |-> stableDone)
        else $error("valid before stable time");
    AST_VALID_EDGE: assert property ($rose(dataValid) |-> $fell(conversionDoneN))
        else $error("valid not set on data-ready edge");
    AST_OSC_AGE: assert property ($rose(oscReady) |->
        $past(oscAge) == CNT_W'(OSC_START_CYC_P - 1)) else $error("oscillator ready too early");
    AST_LATE: assert property ($rose(startupLate) |-> !dataValid && deadlineHit)
        else $error("late flag raised wrongly");

endmodule // aps_power_up_sequencer
`default_nettype wire

// ### rtl/aps_pkg.sv
// Constants, types and lookup functions for the converter start-up sequencer.
// Assumes a single 250 MHz master clock; all counts are in its periods.
package aps_pkg;

    // Clock
    localparam real CLK_PERIOD_NS = 4.0;
    localparam int CLK_HZ = 250_000_000;

    // Counter and rate widths
    localparam int CNT_W = 20;
    localparam int RATE_W = 3;

    // Data rate codes: code k selects 1 kSPS shifted left by k
    localparam logic [RATE_W-1:0] RATE_4K = 3'h2;
    localparam logic [RATE_W-1:0] RATE_MAX = 3'h6;
    localparam logic [RATE_W-1:0] RATE_DEFAULT = RATE_4K;
    localparam int RATE_4K_SPS = 4000;

    // Least start time of the internal oscillator, rounded up
    localparam real OSC_START_US = 20.0;
    localparam int OSC_START_CYC = int'($ceil(OSC_START_US * 1000.0 / CLK_PERIOD_NS));

    // Least time from reset release to valid data, rounded up
    localparam real STABLE_MS = 2.2;
    localparam int STABLE_CYC = int'($ceil(STABLE_MS * 1.0e6 / CLK_PERIOD_NS));

    // Longest time from power-up to valid data, rounded down
    localparam real DEADLINE_MS = 3.0;
    localparam int DEADLINE_CYC = int'($floor(DEADLINE_MS * 1.0e6 / CLK_PERIOD_NS));

    // Conversion period at 4 kSPS
    localparam int CONV_PERIOD_4K_CYC = CLK_HZ / RATE_4K_SPS;

    // Filter settling counts per rate; only the 4 kSPS entry is fixed
    localparam logic [CNT_W-1:0] SETTLE_1K_CYC = 20'h0_2420;
    localparam logic [CNT_W-1:0] SETTLE_2K_CYC = 20'h0_1210;
    localparam logic [CNT_W-1:0] SETTLE_4K_CYC = 20'h0_0908;
    localparam logic [CNT_W-1:0] SETTLE_8K_CYC = 20'h0_0484;
    localparam logic [CNT_W-1:0] SETTLE_16K_CYC = 20'h0_0242;
    localparam logic [CNT_W-1:0] SETTLE_32K_CYC = 20'h0_0121;
    localparam logic [CNT_W-1:0] SETTLE_64K_CYC = 20'h0_0091;

    // Sequencer states
    typedef enum logic [2:0] {ST_OFF, ST_OSC, ST_HOLD, ST_SETTLE, ST_RUN} aps_state_e;

    // Settling count for a rate code
    function automatic logic [CNT_W-1:0] settleCycles(input logic [RATE_W-1:0] rate);
        case (rate)
            3'h0: settleCycles = SETTLE_1K_CYC;
            3'h1: settleCycles = SETTLE_2K_CYC;
            3'h2: settleCycles = SETTLE_4K_CYC;
            3'h3: settleCycles = SETTLE_8K_CYC;
            3'h4: settleCycles = SETTLE_16K_CYC;
            3'h5: settleCycles = SETTLE_32K_CYC;
            default: settleCycles = SETTLE_64K_CYC;
        endcase
    endfunction

endpackage

// ### rtl/aps_timer_if.sv
// Load and expiry signals between the sequencer and one down-counting timer.
// Assumes both ends run on the same master clock.
`timescale 1ns/1ps
`default_nettype none
interface aps_timer_if;
    logic load;
    logic [aps_pkg::CNT_W-1:0] loadValue;
    logic expired;
    logic busy;

    modport ctrl (output load, output loadValue, input expired, input busy);
    modport tmr (input load, input loadValue, output expired, output busy);
endinterface
`default_nettype wire

// ### rtl/aps_timer.sv
// Down-counting interval timer with a one-cycle expiry pulse.
// Assumes loadValue is at least one; a load restarts a running interval.
`timescale 1ns/1ps
`default_nettype none
module aps_timer
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Timer control
    aps_timer_if.tmr bus
);
    import aps_pkg::*;

    logic [CNT_W-1:0] count;
    logic expired;
    logic busy;

    // Next-state decode
    wire lastTick = busy && (count == CNT_W'(1));
    wire [CNT_W-1:0] next_count = bus.load ? bus.loadValue : (count - CNT_W'(1));
    wire next_busy = bus.load || (busy && !lastTick);
    wire next_expired = lastTick && !bus.load;

    // Counter registers
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= '0;
            busy <= 1'b0;
            expired <= 1'b0;
        end
        else
        begin
            if (bus.load || busy)
                count <= next_count;
            busy <= next_busy;
            expired <= next_expired;
        end
    end

    assign bus.expired = expired;
    assign bus.busy = busy;

    // Timer checks
    AST_TMR_LOAD: assert property (@(posedge ref_clk) disable iff (!resetn)
        bus.load |=> busy && !expired) else $error("timer did not start on load");
    AST_TMR_EXPIRE: assert property (@(posedge ref_clk) disable iff (!resetn)
        busy && count == CNT_W'(1) && !bus.load |=> expired && !busy)
        else $error("timer missed its expiry");

endmodule // aps_timer
`default_nettype wire

// ### bench/aps_host_model.sv
// Host model that drives supply, reset pin and command completions.
// Assumes a free-running ref_clk; every pin changes on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module aps_host_model
(
    // Clock
    input wire logic ref_clk,
    // Supply and converter pins
    output logic supplyGood,
    output logic useIntOsc,
    output logic convResetN,
    // Command completion
    output logic regWriteDone,
    output logic rateChangeDone,
    output logic [aps_pkg::RATE_W-1:0] newRate
);
    import aps_pkg::*;

    // Every pin low while unpowered
    task automatic powerDown();
        @(negedge ref_clk);
        {supplyGood, useIntOsc, convResetN, regWriteDone, rateChangeDone} = 5'h00;
        newRate = 3'h0;
    endtask

    initial
    begin
        {supplyGood, useIntOsc, convResetN, regWriteDone, rateChangeDone} = 5'h00;
        newRate = 3'h0;
    end

    // Supply up, then reset pin released some clocks later
    task automatic powerUp(input logic intOsc, input int holdCyc, input logic doRelease);
        @(negedge ref_clk);
        useIntOsc = intOsc;
        supplyGood = 1'b1;
        repeat (holdCyc) @(negedge ref_clk);
        if (doRelease)
            convResetN = 1'b1;
    endtask

    // Drive the converter reset pin
    task automatic setReset(input logic level);
        @(negedge ref_clk);
        convResetN = level;
    endtask

    // One-cycle completion pulse, only issued after reset release
    task automatic pulse(input logic isRate, input logic [RATE_W-1:0] rate);
        @(negedge ref_clk);
        newRate = rate;
        if (isRate)
            rateChangeDone = 1'b1;
        else
            regWriteDone = 1'b1;
        fork
            begin
                @(negedge ref_clk);
                regWriteDone = 1'b0;
                rateChangeDone = 1'b0;
            end
        join_none
    endtask
endmodule // aps_host_model
`default_nettype wire

// ### bench/adc_power_up_sequencing_tb.sv
// Self-checking bench for the converter start-up sequencer.
// Assumes the host model owns all sequencer inputs except clock and reset.
`timescale 1ns/1ps
`default_nettype none
module adc_power_up_sequencing_tb;
    import aps_pkg::*;
    localparam int OSC_P = 8;
    localparam int DEADLINE_P = 6000;
    localparam int CONV_P = 200;
    localparam int SETTLE_4K = 2312;
    typedef struct {logic [2:0] rate; int settle; logic [2:0] expRate;} aps_row_s;
    aps_row_s rows [8] = '{'{3'h0, 9248, 3'h0}, '{3'h1, 4624, 3'h1}, '{3'h3, 1156, 3'h3},
        '{3'h4, 578, 3'h4}, '{3'h5, 289, 3'h5}, '{3'h6, 145, 3'h6}, '{3'h7, 145, 3'h6},
        '{3'h2, 2312, 3'h2}};
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic supplyGood, useIntOsc, convResetN, regWriteDone, rateChangeDone;
    logic [RATE_W-1:0] newRate;
    logic [RATE_W-1:0] dataRate;
    logic oscReady, filterRun, conversionDoneN, firstSettled, dataValid, startupLate;
    int fails = 0;
    int check_count = 0;

    // Master clock, 4 ns period
    always #2 ref_clk = ~ref_clk;

    aps_power_up_sequencer #(.OSC_START_CYC_P(OSC_P), .STABLE_CYC_P(3000),
        .DEADLINE_CYC_P(DEADLINE_P), .CONV_PERIOD_4K_P(CONV_P)) u_aps_power_up_sequencer
    (
        .ref_clk(ref_clk), .resetn(resetn), .supplyGood(supplyGood),
        .useIntOsc(useIntOsc), .convResetN(convResetN), .regWriteDone(regWriteDone),
        .rateChangeDone(rateChangeDone), .newRate(newRate), .oscReady(oscReady),
        .filterRun(filterRun), .conversionDoneN(conversionDoneN),
        .firstSettled(firstSettled), .dataValid(dataValid), .startupLate(startupLate),
        .dataRate(dataRate)
    );

    aps_host_model u_aps_host_model
    (
        .ref_clk(ref_clk), .supplyGood(supplyGood), .useIntOsc(useIntOsc),
        .convResetN(convResetN), .regWriteDone(regWriteDone),
        .rateChangeDone(rateChangeDone), .newRate(newRate)
    );

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s seen %0d expected %0d", $time, what, seen, exp);
        end
    endtask

    // Edges until data-ready goes low, then its pulse width
    task automatic waitDone(output int n);
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        while (conversionDoneN !== 1'b0 && n < 20000);
        @(posedge ref_clk);
        #1;
        check(conversionDoneN, 1'b1, "ready pulse width");
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial
    begin
        #240_000;
        fails++;
        $display("wrong value at %0t: watchdog expired", $time);
        close_out();
    end

    // Main sequence
    initial
    begin : main
        int n;
        int k;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        @(posedge ref_clk);
        #1;
        check({oscReady, filterRun, firstSettled, dataValid, startupLate}, 0, "idle flags");
        check(conversionDoneN, 1'b1, "idle ready");
        check(dataRate, RATE_DEFAULT, "default rate");
        $display("test reset done");
        // External clock start, settle and valid data
        u_aps_host_model.powerUp(1'b0, 2, 1'b1);
        waitDone(n);
        check(n, SETTLE_4K + 2, "first settle");
        check({filterRun, firstSettled, dataValid}, 3'b110, "first data flags");
        waitDone(n);
        check(n, CONV_P - 1, "ready period");
        k = 2;
        while (dataValid !== 1'b1 && k < 8)
        begin
            waitDone(n);
            k++;
        end
        check(k, 5, "valid pulse index");
        check(startupLate, 1'b0, "in time");
        $display("test start-up done");
        // Every rate code, settle counted from command completion
        foreach (rows[i])
        begin
            u_aps_host_model.pulse(1'b1, rows[i].rate);
            waitDone(n);
            check(n, rows[i].settle + 2, "rate settle");
            check(dataRate, rows[i].expRate, "rate code");
        end
        $display("test rates done");
        // Second write in mid-settle restarts the interval
        u_aps_host_model.pulse(1'b0, 3'h0);
        repeat (100) @(negedge ref_clk);
        u_aps_host_model.pulse(1'b0, 3'h0);
        waitDone(n);
        check(n, SETTLE_4K + 2, "write restart");
        check(dataRate, RATE_4K, "write keeps rate");
        $display("test write done");
        // Reset pin low stops the filters
        u_aps_host_model.setReset(1'b0);
        repeat (2) @(posedge ref_clk);
        #1;
        check({filterRun, dataValid}, 2'b00, "filters held");
        $display("test reset pin done");
        // Internal oscillator start, then release in hold
        u_aps_host_model.powerDown();
        u_aps_host_model.powerUp(1'b1, 0, 1'b0);
        n = 0;
        while (oscReady !== 1'b1 && n < 100)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(n >= OSC_P && n <= OSC_P + 2, 1'b1, "osc start");
        u_aps_host_model.setReset(1'b1);
        waitDone(n);
        check(n, SETTLE_4K + 2, "osc settle");
        $display("test oscillator done");
        // Reset never released: deadline flag
        u_aps_host_model.powerDown();
        u_aps_host_model.powerUp(1'b0, 0, 1'b0);
        repeat (DEADLINE_P - 10) @(posedge ref_clk);
        #1;
        check(startupLate, 1'b0, "not yet late");
        repeat (14) @(posedge ref_clk);
        #1;
        check(startupLate, 1'b1, "late");
        $display("test deadline done");
        close_out();
    end
endmodule // adc_power_up_sequencing_tb
`default_nettype wire
